// *** verilog/ea_bus_qualify.sv ***
// Effective-address generation, bus-cycle qualification and interrupt bank handling.
// Assumes sequencer inputs are synchronous to sys_clk_i; registers on Avalon-MM.
//
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/100ps
module ea_bus_qualify (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Address request
  input wire logic ea_start_i,
  input wire ea_pkg::ea_mode_t ea_mode_i,
  input wire logic [15:0] op_offset_i,
  input wire logic [23:0] base_addr_i,
  input wire logic [15:0] index_i,
  input wire logic [15:0] stack_ptr_i,
  input wire logic [1:0] byte_step_i,
  input wire logic step_past_i,
  input wire logic is_store_i,
  input wire logic is_rmw_i,
  output logic [23:0] ea_o,
  output logic ea_valid_o,
  output logic addition_cycle_o,
  // Bus cycle qualification
  input wire ea_pkg::cycle_kind_t cycle_kind_i,
  input wire logic ready_i,
  output logic data_address_valid_o,
  output logic program_address_valid_o,
  output logic address_valid_o,
  output logic write_o,
  output logic halt_o,
  // Interrupts and abort
  input wire logic abort_n_i,
  input wire logic int_start_i,
  input wire logic insn_boundary_i,
  input wire logic status_load_i,
  input wire logic [7:0] status_data_i,
  input wire logic bank_load_i,
  input wire logic [7:0] program_bank_data_i,
  input wire logic [7:0] data_bank_data_i,
  output logic push_bank_o,
  output logic [7:0] push_bank_data_o,
  output logic abort_abandon_o,
  output logic [7:0] program_bank_o,
  output logic [7:0] data_bank_o,
  output logic [7:0] status_o
);
  import ea_pkg::*;

  // Software-visible and sequencer state
  logic emulation_reg;
  logic index16_reg;
  logic [15:0] direct_reg;
  logic [7:0] program_bank_reg;
  logic [7:0] data_bank_reg;
  logic [7:0] status_reg;
  logic abort_latch_reg;
  int_state_t int_state_reg;
  logic [3:0] int_cycle_reg;
  logic int_is_abort_reg;
  // Bus handshake and address arithmetic
  logic ack_reg;
  logic [31:0] rdata_next;
  logic [23:0] ea_next;
  logic add_next;
  logic [15:0] idx_eff;
  logic [15:0] stack_sum;
  logic [15:0] direct_sum;
  logic [7:0] page_low;
  logic [8:0] abs_low;
  logic [15:0] stack_step_sum;
  logic [15:0] long_sum;
  logic wr_hit;
  logic rd_hit;
  // Interrupt sequence decodes
  logic bank_cycle;
  logic abort_clear;
  logic abort_kill;

  // One wait state per access; a write lands only at the edge with waitrequest low
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
  assign wr_hit = avs_write_i & ack_reg;
  assign rd_hit = avs_read_i & ~ack_reg; // Data captured early so it stands at the accept edge

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) ack_reg <= 1'b0;
    else ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (avs_address_i)
      OFS_CTRL: rdata_next = {30'h0, index16_reg, emulation_reg};
      OFS_DIRECT: rdata_next = {16'h0, direct_reg};
      OFS_BANKS: rdata_next = {15'h0, abort_latch_reg, program_bank_reg, data_bank_reg};
      OFS_STATUS: rdata_next = {24'h0, status_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Read data registered in the wait cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) avs_readdata_o <= 32'h0000_0000;
    else if (rd_hit) avs_readdata_o <= rdata_next;
  end

  // Control and direct registers written by software
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      emulation_reg <= CTRL_EMU_RST;
      index16_reg <= CTRL_IDX16_RST;
      direct_reg <= DIRECT_RST;
    end else if (wr_hit) begin
      if (avs_address_i == OFS_CTRL && avs_byteenable_i[0]) begin
        emulation_reg <= avs_writedata_i[CTRL_EMU_BIT];
        index16_reg <= avs_writedata_i[CTRL_IDX16_BIT];
      end
      if (avs_address_i == OFS_DIRECT) begin
        if (avs_byteenable_i[0]) direct_reg[7:0] <= avs_writedata_i[7:0];
        if (avs_byteenable_i[1]) direct_reg[15:8] <= avs_writedata_i[15:8];
      end
    end
  end

  // Index width forced to 8 bits in emulation
  assign idx_eff = (index16_reg & ~emulation_reg) ? index_i : {8'h00, index_i[7:0]};
  assign stack_sum = 16'(stack_ptr_i + op_offset_i + 16'(byte_step_i));
  assign page_low = 8'(op_offset_i[7:0] + ((ea_mode_i == EA_DIRECT_Y) ? idx_eff[7:0] :
                       (ea_mode_i == EA_DIRECT_X) ? idx_eff[7:0] : 8'h00));
  assign direct_sum = 16'(direct_reg + op_offset_i + (((ea_mode_i == EA_DIRECT_X) ||
                       (ea_mode_i == EA_DIRECT_Y)) ? idx_eff : 16'h0000) + 16'(byte_step_i));
  assign abs_low = {1'b0, base_addr_i[7:0]} + {1'b0, idx_eff[7:0]};
  assign stack_step_sum = 16'({STACK_PAGE, stack_ptr_i[7:0]} + op_offset_i + 16'(byte_step_i));
  assign long_sum = 16'({direct_reg[15:8], page_low} + 16'(byte_step_i));

  // Effective address by mode and emulation flag
  always_comb begin
    ea_next = 24'h00_0000;
    add_next = 1'b0;
    unique case (ea_mode_i)
      EA_STACK, EA_STACK_REL: begin
        if (!emulation_reg) ea_next = {ZERO_BANK, stack_sum};
        else if (step_past_i)
          ea_next = {ZERO_BANK, stack_step_sum};
        else ea_next = {ZERO_BANK, STACK_PAGE, stack_sum[7:0]};
      end
      EA_DIRECT, EA_DIRECT_X, EA_DIRECT_Y: begin
        if (!emulation_reg || direct_reg[7:0] != 8'h00)
          ea_next = {ZERO_BANK, direct_sum};
        else ea_next = {ZERO_BANK, direct_reg[15:8], 8'(page_low + 8'(byte_step_i))};
      end
      EA_DIRECT_LONG, EA_PUSH_IND: begin
        if (!emulation_reg || direct_reg[7:0] != 8'h00) ea_next = {ZERO_BANK, direct_sum};
        else ea_next = {ZERO_BANK, long_sum};
      end
      EA_ABS_INDEXED: begin
        ea_next = 24'(base_addr_i + {8'h00, idx_eff});
        add_next = is_store_i | is_rmw_i | (index16_reg & ~emulation_reg) | abs_low[8];
      end
      default: ea_next = 24'h00_0000;
    endcase
  end

  // Address result registered on request
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ea_o <= 24'h00_0000;
      ea_valid_o <= 1'b0;
      addition_cycle_o <= 1'b0;
    end else begin
      ea_valid_o <= ea_start_i;
      if (ea_start_i) begin
        ea_o <= ea_next;
        addition_cycle_o <= add_next;
      end
    end
  end

  // Valid-address qualifiers per bus cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      data_address_valid_o <= 1'b0;
      program_address_valid_o <= 1'b0;
      address_valid_o <= 1'b0;
      write_o <= 1'b0;
    end else begin
      data_address_valid_o <= (cycle_kind_i == CYC_READ) | (cycle_kind_i == CYC_WRITE) |
                              (cycle_kind_i == CYC_MODIFY);
      program_address_valid_o <= (cycle_kind_i == CYC_OPCODE) | (cycle_kind_i == CYC_OPERAND);
      address_valid_o <= (cycle_kind_i != CYC_INTERNAL);
      write_o <= (cycle_kind_i == CYC_WRITE);
    end
  end

  // Ready low stalls, except writes in emulation
  assign halt_o = ~ready_i & ~(write_o & emulation_reg);

  // Sequence cycle decodes for bank clear, abort clear and abandon
  assign bank_cycle = (int_state_reg == INT_RUN) && (int_cycle_reg == INT_BANK_CYCLE);
  assign abort_clear = (int_state_reg == INT_RUN) && int_is_abort_reg && (int_cycle_reg == ABORT_CLEAR_CYCLE);
  assign abort_kill = (int_state_reg == INT_RUN) && int_is_abort_reg && !abort_n_i;

  // Interrupt sequencer
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      int_state_reg <= INT_IDLE;
      int_cycle_reg <= 4'h0;
      int_is_abort_reg <= 1'b0;
      abort_abandon_o <= 1'b0;
    end else begin
      abort_abandon_o <= abort_kill;
      unique case (int_state_reg)
        INT_IDLE: begin
          if (insn_boundary_i && (abort_latch_reg || int_start_i)) begin
            int_state_reg <= INT_RUN;
            int_cycle_reg <= 4'h1;
            int_is_abort_reg <= abort_latch_reg;
          end
        end
        INT_RUN: begin
          if (abort_kill || int_cycle_reg == INT_SEQ_LEN) begin
            int_state_reg <= INT_IDLE;
            int_cycle_reg <= 4'h0;
          end else int_cycle_reg <= 4'(int_cycle_reg + 4'h1);
        end
      endcase
    end
  end

  // Abort latch; a new request during an abort sequence abandons it, so the cycle-two clear wins
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) abort_latch_reg <= 1'b0;
    else if (!abort_n_i && !abort_kill) abort_latch_reg <= 1'b1;
    else if (abort_clear || abort_kill) abort_latch_reg <= 1'b0;
  end

  // Program bank cleared in interrupt cycle two; data bank cleared too only in emulation
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      program_bank_reg <= BANK_RST;
      data_bank_reg <= BANK_RST;
    end else if (bank_cycle) begin
      program_bank_reg <= ZERO_BANK;
      if (emulation_reg) data_bank_reg <= ZERO_BANK;
    end else if (bank_load_i) begin
      program_bank_reg <= program_bank_data_i;
      data_bank_reg <= data_bank_data_i;
    end
  end

  // Old program bank pushed in native mode
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      push_bank_o <= 1'b0;
      push_bank_data_o <= 8'h00;
    end else begin
      push_bank_o <= bank_cycle & ~emulation_reg;
      if (bank_cycle) push_bank_data_o <= program_bank_reg;
    end
  end

  // Status commits at once and is never rolled back; decimal clear wins
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) status_reg <= STATUS_RST;
    else begin
      if (status_load_i) status_reg <= status_data_i;
      if (bank_cycle) status_reg[STAT_DEC_BIT] <= 1'b0;
    end
  end

  // Bank and status registers straight out
  assign program_bank_o = program_bank_reg;
  assign data_bank_o = data_bank_reg;
  assign status_o = status_reg;
endmodule // ea_bus_qualify

// *** verilog/ea_pkg.sv ***
// Constants and types for the effective-address and bus-qualify block.
// Assumes a single 100 MHz clock domain and a 32-bit Avalon-MM register port.
package ea_pkg;
  // Register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_DIRECT = 4'h4;
  localparam logic [3:0] OFS_BANKS = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  // Control field positions
  localparam int CTRL_EMU_BIT = 0;
  localparam int CTRL_IDX16_BIT = 1;
  // Status register field positions
  localparam int STAT_DEC_BIT = 3;
  // Reset values
  localparam logic CTRL_EMU_RST = 1'b1;
  localparam logic CTRL_IDX16_RST = 1'b0;
  localparam logic [15:0] DIRECT_RST = 16'h0000;
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h34;
  // Fixed pages and banks
  localparam logic [7:0] ZERO_BANK = 8'h00;
  localparam logic [7:0] STACK_PAGE = 8'h01;
  // Interrupt sequence timing, in processor cycles
  localparam logic [3:0] INT_BANK_CYCLE = 4'h2;
  localparam logic [3:0] ABORT_CLEAR_CYCLE = 4'h2;
  localparam logic [3:0] INT_SEQ_LEN = 4'h7;
  // Addressing modes
  typedef enum logic [2:0] {
    EA_STACK, EA_STACK_REL, EA_DIRECT, EA_DIRECT_X,
    EA_DIRECT_Y, EA_DIRECT_LONG, EA_PUSH_IND, EA_ABS_INDEXED
  } ea_mode_t;
  // Bus cycle kinds
  typedef enum logic [2:0] {
    CYC_OPCODE, CYC_OPERAND, CYC_READ, CYC_WRITE, CYC_MODIFY, CYC_INTERNAL
  } cycle_kind_t;
  // Interrupt sequencer states
  typedef enum logic [1:0] {INT_IDLE, INT_RUN} int_state_t;
endpackage

// *** tb/ea_bus_qualify_properties.sv ***
// Port checker for ea_bus_qualify.
// Assumes it is bound to the design top and sees only its ports.
`timescale 1ns/100ps
module ea_bus_qualify_properties import ea_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ea_start_i,
  input wire ea_pkg::ea_mode_t ea_mode_i,
  input wire logic [23:0] base_addr_i,
  input wire logic [15:0] index_i,
  input wire logic is_store_i,
  input wire logic is_rmw_i,
  input wire logic [23:0] ea_o,
  input wire logic ea_valid_o,
  input wire logic addition_cycle_o,
  input wire ea_pkg::cycle_kind_t cycle_kind_i,
  input wire logic address_valid_o,
  input wire logic write_o,
  input wire logic push_bank_o,
  input wire logic [7:0] program_bank_o,
  input wire logic [7:0] status_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Address request of one mode, and one with an 8-bit index
  sequence s_req(m);
    ea_start_i && ea_mode_i == m;
  endsequence
  sequence s_abs_short;
    s_req(EA_ABS_INDEXED) ##0 index_i[15:8] == 8'h00;
  endsequence
  a_ea_answer: assert property ($past(rst_n_i) |-> ea_valid_o == $past(ea_start_i)) else $error("ea answer wrong");
  a_stack_bank: assert property (s_req(EA_STACK) |=> ea_o[23:16] == ZERO_BANK)
    else $error("stack left bank zero");
  a_abs_carry: assert property (s_abs_short |=> ea_o == $past(base_addr_i) + {8'h00, $past(index_i)})
    else $error("bank carry wrong");
  a_store_addition: assert property (s_req(EA_ABS_INDEXED) ##0 (is_store_i || is_rmw_i) |=> addition_cycle_o)
    else $error("addition cycle missing");
  a_valid_kind: assert property ($past(rst_n_i) |-> address_valid_o == ($past(cycle_kind_i) != CYC_INTERNAL))
    else $error("address valid wrong");
  a_write_kind: assert property ($past(rst_n_i) |-> write_o == ($past(cycle_kind_i) == CYC_WRITE))
    else $error("write flag wrong");
  a_push_zero: assert property (push_bank_o |-> program_bank_o == ZERO_BANK && !status_o[STAT_DEC_BIT])
    else $error("bank or decimal not cleared");
  a_push_pulse: assert property (push_bank_o |=> !push_bank_o)
    else $error("bank push too long");
endmodule // ea_bus_qualify_properties
bind ea_bus_qualify ea_bus_qualify_properties chk (.*);

// *** tb/bus_memory_model.sv ***
// Memory and decode side of the processor bus.
// Assumes the design clock; the bench asks for abort pulses.
`timescale 1ns/100ps
module bus_memory_model (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic data_address_valid_i,
  input wire logic program_address_valid_i,
  input wire logic abort_req_i,
  output logic abort_n_o,
  output int accesses_o
);
  // Abort low for one cycle at a time; a held request pulses it low every other cycle
  always_ff @(posedge sys_clk_i) begin
    abort_n_o <= !rst_n_i || !(abort_req_i && abort_n_o);
  end
  // Only qualified cycles reach memory
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) accesses_o <= 0;
    else if (data_address_valid_i || program_address_valid_i) accesses_o <= accesses_o + 1;
  end
endmodule // bus_memory_model

// *** tb/ea_bus_qualify_test.sv ***
// Self-checking bench for ea_bus_qualify.
// Assumes a 100 MHz clock and the bus memory model beside the design.
`timescale 1ns/100ps
module ea_bus_qualify_test;
  import ea_pkg::*;
  logic sys_clk_i = 0, rst_n_i = 0, avs_read_i = 0, avs_write_i = 0, ea_start_i = 0;
  logic step_past_i = 0, is_store_i = 0, is_rmw_i = 0, ready_i = 1, int_start_i = 0;
  logic insn_boundary_i = 0, status_load_i = 0, bank_load_i = 0, abort_req = 0;
  logic [3:0] avs_address_i = 0, avs_byteenable_i = 4'hF;
  logic [31:0] avs_writedata_i = 0, avs_readdata_o, q;
  logic [1:0] byte_step_i = 0;
  logic [15:0] op_offset_i = 0, index_i = 0, stack_ptr_i = 0;
  logic [23:0] base_addr_i = 0, ea_o;
  logic [7:0] status_data_i = 0, program_bank_data_i = 0, data_bank_data_i = 0;
  logic [7:0] push_bank_data_o, program_bank_o, data_bank_o, status_o;
  ea_mode_t ea_mode_i = EA_STACK;
  cycle_kind_t cycle_kind_i = CYC_INTERNAL;
  logic avs_waitrequest_o, ea_valid_o, addition_cycle_o, data_address_valid_o, program_address_valid_o;
  logic address_valid_o, write_o, halt_o, abort_n_i, push_bank_o, abort_abandon_o;
  int n_errors = 0, samples_checked = 0, n, acc;
  always #5 sys_clk_i = ~sys_clk_i;
  ea_bus_qualify DUT (.*);
  bus_memory_model mem (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .data_address_valid_i(data_address_valid_o),
    .program_address_valid_i(program_address_valid_o), .abort_req_i(abort_req), .abort_n_o(abort_n_i),
    .accesses_o(acc));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Avalon word access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 0;
    avs_read_i <= 0;
  endtask
  // One address request, answer looked at one cycle on
  task automatic ea(input ea_mode_t m, input logic [15:0] off, input logic [15:0] idx, input logic [23:0] exp);
    @(posedge sys_clk_i);
    ea_mode_i <= m;
    op_offset_i <= off;
    index_i <= idx;
    ea_start_i <= 1;
    @(posedge sys_clk_i);
    ea_start_i <= 0;
    @(negedge sys_clk_i);
    chk("ea_valid", 1, ea_valid_o);
    chk("ea", exp, ea_o);
    @(posedge sys_clk_i);
  endtask
  task automatic t_regs;
    bus(0, OFS_CTRL, 0);
    chk("ctrl", 32'h1, q);
    bus(1, OFS_STATUS, 32'hFF);
    bus(0, OFS_STATUS, 0);
    chk("status", 32'h34, q);
    bus(0, 4'h2, 0);
    chk("unmapped", 32'h0, q);
    $display("regs done");
  endtask
  task automatic t_stack;
    @(posedge sys_clk_i);
    stack_ptr_i <= 16'h01F0;
    ea(EA_STACK, 16'h0020, 16'h0, 24'h000110);
    step_past_i <= 1;
    ea(EA_STACK, 16'h0020, 16'h0, 24'h000210);
    step_past_i <= 0;
    bus(1, OFS_CTRL, 32'h0);
    stack_ptr_i <= 16'hFFF0;
    ea(EA_STACK, 16'h0020, 16'h0, 24'h000010);
    bus(1, OFS_CTRL, 32'h1);
    $display("stack done");
  endtask
  task automatic t_direct;
    @(posedge sys_clk_i);
    byte_step_i <= 1;
    ea(EA_DIRECT_X, 16'h00F0, 16'h0020, 24'h000011);
    ea(EA_DIRECT_LONG, 16'h00FF, 16'h0, 24'h000100);
    bus(1, OFS_DIRECT, 32'h1200);
    ea(EA_DIRECT_Y, 16'h00F0, 16'h0020, 24'h001211);
    ea(EA_PUSH_IND, 16'h00FF, 16'h0, 24'h001300);
    bus(1, OFS_DIRECT, 32'h0012);
    ea(EA_DIRECT, 16'h00F0, 16'h0, 24'h000103);
    bus(1, OFS_DIRECT, 32'h0);
    bus(1, OFS_CTRL, 32'h0);
    ea(EA_DIRECT_X, 16'hFFF0, 16'h0020, 24'h000011);
    byte_step_i <= 0;
    $display("direct done");
  endtask
  task automatic t_abs;
    bus(1, OFS_CTRL, 32'h2);
    base_addr_i <= 24'h12FFF0;
    ea(EA_ABS_INDEXED, 16'h0, 16'h0020, 24'h130010);
    chk("addition", 1, addition_cycle_o);
    bus(1, OFS_CTRL, 32'h1);
    base_addr_i <= 24'h000010;
    ea(EA_ABS_INDEXED, 16'h0, 16'h0005, 24'h000015);
    chk("addition", 0, addition_cycle_o);
    is_store_i <= 1;
    ea(EA_ABS_INDEXED, 16'h0, 16'h0005, 24'h000015);
    chk("addition", 1, addition_cycle_o);
    is_store_i <= 0;
    base_addr_i <= 24'h0000F0;
    ea(EA_ABS_INDEXED, 16'h0, 16'h0020, 24'h000110);
    chk("addition_cross", 1, addition_cycle_o);
    $display("abs done");
  endtask
  task automatic t_bus;
    for (int k = 0; k < 6; k++) begin
      @(posedge sys_clk_i);
      cycle_kind_i <= cycle_kind_t'(k);
      @(negedge sys_clk_i);
      @(negedge sys_clk_i);
      chk("addr_valid", k != 5, address_valid_o);
      chk("write", k == 3, write_o);
      chk("data_valid", k >= 2 && k <= 4, data_address_valid_o);
      chk("prog_valid", k <= 1, program_address_valid_o);
    end
    n = acc;
    repeat (2) @(negedge sys_clk_i);
    chk("accesses", n, acc);
    @(posedge sys_clk_i);
    cycle_kind_i <= CYC_WRITE;
    ready_i <= 0;
    @(negedge sys_clk_i);
    @(negedge sys_clk_i);
    chk("halt_emu", 0, halt_o);
    bus(1, OFS_CTRL, 32'h0);
    @(negedge sys_clk_i);
    chk("halt_native", 1, halt_o);
    @(posedge sys_clk_i);
    ready_i <= 1;
    cycle_kind_i <= CYC_INTERNAL;
    $display("bus done");
  endtask
  // Interrupt entry; emu selects the mode written first
  task automatic t_int(input logic emu);
    bus(1, OFS_CTRL, {31'h0, emu});
    bank_load_i <= 1;
    program_bank_data_i <= 8'h5A;
    data_bank_data_i <= 8'h3C;
    status_load_i <= 1;
    status_data_i <= 8'hFF;
    @(posedge sys_clk_i);
    bank_load_i <= 0;
    status_load_i <= 0;
    int_start_i <= 1;
    insn_boundary_i <= 1;
    @(posedge sys_clk_i);
    int_start_i <= 0;
    insn_boundary_i <= 0;
    for (n = 0; n < 20 && program_bank_o !== 8'h00; n++) @(negedge sys_clk_i);
    chk("push", !emu, push_bank_o);
    if (!emu) chk("push_data", 8'h5A, push_bank_data_o);
    chk("dbank", emu ? 8'h00 : 8'h3C, data_bank_o);
    chk("status", 8'hF7, status_o);
    repeat (8) @(posedge sys_clk_i);
    $display("int done");
  endtask
  task automatic t_abort;
    @(posedge sys_clk_i);
    abort_req <= 1;
    insn_boundary_i <= 1;
    status_load_i <= 1;
    status_data_i <= 8'hC0;
    @(posedge sys_clk_i);
    abort_req <= 0;
    status_load_i <= 0;
    repeat (3) @(posedge sys_clk_i);
    insn_boundary_i <= 0;
    abort_req <= 1;
    @(posedge sys_clk_i);
    abort_req <= 0;
    for (n = 0; n < 10 && abort_abandon_o !== 1'b1; n++) @(negedge sys_clk_i);
    chk("abandon", 1, abort_abandon_o);
    chk("status_kept", 8'hC0, status_o);
    bus(0, OFS_BANKS, 0);
    chk("latch", 0, q[16]);
    $display("abort done");
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog well beyond the whole sequence
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    n_errors++;
    end_sim;
  end
  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1;
    t_regs;
    t_stack;
    t_direct;
    t_abs;
    t_bus;
    t_int(0);
    t_int(1);
    t_abort;
    end_sim;
  end
endmodule // ea_bus_qualify_test
